// file: common/ftcs_pkg.sv
// Purpose: shared constants of the transfer command setup block
// Assumes: 25 MHz core clock
// Notes: opcodes are the low five bits of the first command byte
package ftcs_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int STEP_UNIT_NS = 500000;
  localparam int STEP_UNIT_CYC = (STEP_UNIT_NS + CLK_PERIOD_NS - 1) /
    CLK_PERIOD_NS;
  localparam int STEP_CODE_SPAN = 16;
  localparam logic [4:0] OP_READ = 5'h06;
  localparam logic [4:0] OP_READ_DEL = 5'h0C;
  localparam logic [4:0] OP_WRITE = 5'h05;
  localparam logic [4:0] OP_WRITE_DEL = 5'h09;
  localparam logic [4:0] OP_VERIFY = 5'h16;
  localparam logic [4:0] OP_FORMAT = 5'h0D;
  localparam logic [4:0] OP_OFFSET_SEEK = 5'h0F;
  localparam int OFFSET_DIR_BIT = 6;
  localparam logic [1:0] IC_NORMAL = 2'h0;
  localparam logic [1:0] IC_ABNORMAL = 2'h1;
  localparam logic [1:0] IC_INVALID = 2'h2;
  localparam int ST0_IC_POS = 6;
  localparam int ST0_SEEK_END_POS = 5;
  localparam int ST0_EQUIP_POS = 4;
  localparam int ST0_HEAD_POS = 2;
  localparam int ST3_FAULT_POS = 7;
  localparam int ST3_TRACK0_POS = 4;
  localparam logic [7:0] CYL_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  typedef enum logic [1:0] {
    FTCS_K_READ = 2'b00,
    FTCS_K_WRITE = 2'b01,
    FTCS_K_VERIFY = 2'b10,
    FTCS_K_FORMAT = 2'b11
  } ftcs_kind_t;
endpackage

// file: common/ftcs_step_if.sv
// Purpose: link between the sequencer and its step interval timer
// Assumes: one clock domain
// Notes: start is a one-cycle pulse, done a one-cycle pulse
`timescale 1ns/1ns
`default_nettype none
interface ftcs_step_if;
  logic start;
  logic [4:0] units;
  logic done;
  modport ctl (output start, output units, input done);
  modport tmr (input start, input units, output done);
endinterface
`default_nettype wire

// file: core/ftcs_step_timer.sv
// Purpose: counts a number of step units after a start pulse
// Assumes: units nonzero
// Notes: a new start restarts the count
`timescale 1ns/1ns
`default_nettype none
module ftcs_step_timer
  import ftcs_pkg::*;
#(
  parameter int UNIT_CYC = STEP_UNIT_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  ftcs_step_if.tmr tif
);
  if (UNIT_CYC < 1 || UNIT_CYC > 65535) begin : g_bad_unit
    $error("UNIT_CYC out of range");
  end
  logic [15:0] cyc_r, cyc_nxt;
  logic [4:0] left_r, left_nxt;
  logic run_r, run_nxt;
  logic done_r, done_nxt;
  always_comb begin
    cyc_nxt = cyc_r;
    left_nxt = left_r;
    run_nxt = run_r;
    done_nxt = 1'b0;
    if (tif.start) begin
      run_nxt = 1'b1;
      cyc_nxt = 16'(UNIT_CYC - 1);
      left_nxt = tif.units;
    end else if (run_r) begin
      if (cyc_r != 16'h0000) begin
        cyc_nxt = cyc_r - 16'h0001;
      end else if (left_r <= 5'h01) begin
        run_nxt = 1'b0;
        done_nxt = 1'b1;
      end else begin
        left_nxt = left_r - 5'h01;
        cyc_nxt = 16'(UNIT_CYC - 1);
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cyc_r <= 16'h0000;
      left_r <= 5'h00;
      run_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      cyc_r <= cyc_nxt;
      left_r <= left_nxt;
      run_r <= run_nxt;
      done_r <= done_nxt;
    end
  end
  assign tif.done = done_r;
endmodule // ftcs_step_timer
`default_nettype wire

// file: core/ftcs_setup.sv
// What this block does
// - Transfer commands share parameters, differ by opcode
// - Implied seek runs when setup option enabled
// - Drive busy flag asserted during seek
// - Seek failure reported in status and cylinder
// - Four result status bytes captured per command
// - Write gate option changes write enable timing
// - Precompensation start track spans 00 to FF
// - Sector address is first sector transferred
// - Format uses sector count as sectors
// - Verify with count flag uses sector count
// - Polling disabled while disable bit set
// - Offset seek cylinder is relative to present
// - Step spacing 0.5 to 8 ms steps
//
// Purpose: setup and implied seek for floppy transfer commands
// Assumes: command bytes already gathered; transfer engine outside
// Notes: step unit is scaled by UNIT_CYC for simulation
`timescale 1ns/1ns
`default_nettype none
module ftcs_setup
  import ftcs_pkg::*;
#(
  parameter int UNIT_CYC = STEP_UNIT_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic [1:0] cmd_drive,
  input wire logic cmd_head,
  input wire logic [7:0] cmd_cyl,
  input wire logic [7:0] cmd_sector,
  input wire logic [7:0] sector_count,
  input wire logic enable_count_flag,
  input wire logic cfg_implied_seek,
  input wire logic cfg_poll_disable,
  input wire logic write_gate_option,
  input wire logic [7:0] precomp_track,
  input wire logic [3:0] step_interval,
  input wire logic drive_fault,
  input wire logic drive_track0,
  input wire logic wr_req,
  input wire logic xfer_done,
  input wire logic xfer_fail,
  input wire logic [7:0] xfer_st1,
  input wire logic [7:0] xfer_st2,
  output logic cmd_ready_r,
  output logic [3:0] drive_busy_r,
  output logic step_pulse_r,
  output logic step_dir_r,
  output logic xfer_start_r,
  output logic [1:0] xfer_kind_r,
  output logic [7:0] xfer_first_sector_r,
  output logic [7:0] xfer_count_r,
  output logic xfer_count_en_r,
  output logic precomp_en_r,
  output logic drive_we_r,
  output logic poll_active_r,
  output logic result_valid_r,
  output logic [7:0] first_result_status_r,
  output logic [7:0] result_st1_r,
  output logic [7:0] result_st2_r,
  output logic [7:0] result_st3_r,
  output logic [7:0] result_cyl_r
);
  typedef enum logic [2:0] {
    FTCS_IDLE = 3'b000,
    FTCS_STEP = 3'b001,
    FTCS_WAIT = 3'b010,
    FTCS_XSTART = 3'b011,
    FTCS_XRUN = 3'b100,
    FTCS_DONE = 3'b101
  } ftcs_state_t;

  ftcs_step_if sif ();
  ftcs_step_timer #(.UNIT_CYC(UNIT_CYC)) u_timer (
    .clk(clk),
    .rst_b(rst_b),
    .tif(sif)
  );

  ftcs_state_t st_r, st_nxt;
  logic [7:0] pcyl_r [4];
  logic [7:0] pcyl_nxt [4];
  logic [7:0] tgt_r, tgt_nxt;
  logic [1:0] drv_r, drv_nxt;
  logic head_r, head_nxt;
  logic seek_only_r, seek_only_nxt;
  logic fail_r, fail_nxt;
  logic bad_r, bad_nxt;
  logic wr_d_r;
  logic cmd_ready_nxt, step_pulse_nxt, step_dir_nxt, xfer_start_nxt;
  logic [1:0] kind_nxt;
  logic [7:0] first_nxt, count_nxt;
  logic count_en_nxt, result_valid_nxt;
  logic [3:0] busy_nxt;
  logic [7:0] st0_nxt, st1_nxt, st2_nxt, st3_nxt, rcyl_nxt;
  logic [4:0] opc;
  logic [8:0] rel_sum;
  logic [7:0] cur;

  assign opc = cmd_opcode[4:0];
  assign cur = pcyl_r[drv_r];
  assign sif.units = 5'(STEP_CODE_SPAN) - {1'b0, step_interval};
  assign sif.start = step_pulse_r;
  assign rel_sum = cmd_opcode[OFFSET_DIR_BIT] ?
    ({1'b0, pcyl_r[cmd_drive]} - {1'b0, cmd_cyl}) :
    ({1'b0, pcyl_r[cmd_drive]} + {1'b0, cmd_cyl});

  always_comb begin
    st_nxt = st_r;
    pcyl_nxt = pcyl_r;
    tgt_nxt = tgt_r;
    drv_nxt = drv_r;
    head_nxt = head_r;
    seek_only_nxt = seek_only_r;
    fail_nxt = fail_r;
    bad_nxt = bad_r;
    cmd_ready_nxt = 1'b0;
    step_pulse_nxt = 1'b0;
    step_dir_nxt = step_dir_r;
    xfer_start_nxt = 1'b0;
    kind_nxt = xfer_kind_r;
    first_nxt = xfer_first_sector_r;
    count_nxt = xfer_count_r;
    count_en_nxt = xfer_count_en_r;
    result_valid_nxt = 1'b0;
    busy_nxt = drive_busy_r;
    st0_nxt = first_result_status_r;
    st1_nxt = result_st1_r;
    st2_nxt = result_st2_r;
    st3_nxt = result_st3_r;
    rcyl_nxt = result_cyl_r;
    unique case (st_r)
      FTCS_IDLE: begin
        cmd_ready_nxt = 1'b1;
        if (cmd_valid) begin
          cmd_ready_nxt = 1'b0;
          drv_nxt = cmd_drive;
          head_nxt = cmd_head;
          fail_nxt = 1'b0;
          bad_nxt = 1'b0;
          seek_only_nxt = 1'b0;
          tgt_nxt = cmd_cyl;
          first_nxt = cmd_sector;
          count_nxt = sector_count;
          count_en_nxt = 1'b0;
          st_nxt = cfg_implied_seek ? FTCS_STEP : FTCS_XSTART;
          unique case (opc)
            OP_READ, OP_READ_DEL: kind_nxt = FTCS_K_READ;
            OP_WRITE, OP_WRITE_DEL: kind_nxt = FTCS_K_WRITE;
            OP_VERIFY: begin
              kind_nxt = FTCS_K_VERIFY;
              count_en_nxt = enable_count_flag;
            end
            OP_FORMAT: begin
              kind_nxt = FTCS_K_FORMAT;
              count_en_nxt = 1'b1;
            end
            OP_OFFSET_SEEK: begin
              seek_only_nxt = 1'b1;
              tgt_nxt = rel_sum[7:0];
              fail_nxt = rel_sum[8];
              st_nxt = FTCS_STEP;
            end
            default: begin
              bad_nxt = 1'b1;
              st_nxt = FTCS_DONE;
            end
          endcase
        end
      end
      FTCS_STEP: begin
        busy_nxt[drv_r] = 1'b1;
        if (fail_r || drive_fault) begin
          fail_nxt = 1'b1;
          st1_nxt = STATUS_RESET;
          st2_nxt = STATUS_RESET;
          st_nxt = FTCS_DONE;
        end else if (cur == tgt_r) begin
          busy_nxt[drv_r] = 1'b0;
          st_nxt = seek_only_r ? FTCS_DONE : FTCS_XSTART;
        end else begin
          step_pulse_nxt = 1'b1;
          step_dir_nxt = tgt_r > cur;
          pcyl_nxt[drv_r] = (tgt_r > cur) ? cur + 8'h01 : cur - 8'h01;
          st_nxt = FTCS_WAIT;
        end
      end
      FTCS_WAIT: begin
        if (sif.done) begin
          st_nxt = FTCS_STEP;
        end
      end
      FTCS_XSTART: begin
        xfer_start_nxt = 1'b1;
        st_nxt = FTCS_XRUN;
      end
      FTCS_XRUN: begin
        if (xfer_done) begin
          fail_nxt = xfer_fail;
          st1_nxt = xfer_st1;
          st2_nxt = xfer_st2;
          st_nxt = FTCS_DONE;
        end
      end
      FTCS_DONE: begin
        busy_nxt[drv_r] = 1'b0;
        result_valid_nxt = 1'b1;
        if (!fail_r && seek_only_r) begin
          st1_nxt = STATUS_RESET;
          st2_nxt = STATUS_RESET;
        end
        st0_nxt = {fail_r ? IC_ABNORMAL : IC_NORMAL,
                   seek_only_r, fail_r && drive_fault, 1'b0,
                   head_r, drv_r};
        if (bad_r) begin
          st0_nxt = {IC_INVALID, 3'h0, head_r, drv_r};
        end
        rcyl_nxt = cur;
        st3_nxt = {drive_fault, 2'h0, drive_track0, 1'b0, head_r, drv_r};
        st_nxt = FTCS_IDLE;
      end
      default: st_nxt = FTCS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= FTCS_IDLE;
      for (int i = 0; i < 4; i++) begin
        pcyl_r[i] <= CYL_RESET;
      end
      tgt_r <= CYL_RESET;
      drv_r <= 2'h0;
      head_r <= 1'b0;
      seek_only_r <= 1'b0;
      fail_r <= 1'b0;
      bad_r <= 1'b0;
      wr_d_r <= 1'b0;
      cmd_ready_r <= 1'b0;
      drive_busy_r <= 4'h0;
      step_pulse_r <= 1'b0;
      step_dir_r <= 1'b0;
      xfer_start_r <= 1'b0;
      xfer_kind_r <= FTCS_K_READ;
      xfer_first_sector_r <= 8'h00;
      xfer_count_r <= 8'h00;
      xfer_count_en_r <= 1'b0;
      precomp_en_r <= 1'b0;
      drive_we_r <= 1'b0;
      poll_active_r <= 1'b0;
      result_valid_r <= 1'b0;
      first_result_status_r <= STATUS_RESET;
      result_st1_r <= STATUS_RESET;
      result_st2_r <= STATUS_RESET;
      result_st3_r <= STATUS_RESET;
      result_cyl_r <= CYL_RESET;
    end else begin
      st_r <= st_nxt;
      pcyl_r <= pcyl_nxt;
      tgt_r <= tgt_nxt;
      drv_r <= drv_nxt;
      head_r <= head_nxt;
      seek_only_r <= seek_only_nxt;
      fail_r <= fail_nxt;
      bad_r <= bad_nxt;
      wr_d_r <= wr_req;
      cmd_ready_r <= cmd_ready_nxt;
      drive_busy_r <= busy_nxt;
      step_pulse_r <= step_pulse_nxt;
      step_dir_r <= step_dir_nxt;
      xfer_start_r <= xfer_start_nxt;
      xfer_kind_r <= kind_nxt;
      xfer_first_sector_r <= first_nxt;
      xfer_count_r <= count_nxt;
      xfer_count_en_r <= count_en_nxt;
      precomp_en_r <= cur >= precomp_track;
      drive_we_r <= write_gate_option ? (wr_req | wr_d_r) : wr_d_r;
      poll_active_r <= !cfg_poll_disable && st_nxt == FTCS_IDLE;
      result_valid_r <= result_valid_nxt;
      first_result_status_r <= st0_nxt;
      result_st1_r <= st1_nxt;
      result_st2_r <= st2_nxt;
      result_st3_r <= st3_nxt;
      result_cyl_r <= rcyl_nxt;
    end
  end
endmodule // ftcs_setup
`default_nettype wire

// file: testbench/ftcs_setup_sva.sv
// Purpose: port assertions for ftcs_setup
// Assumes: UNIT_CYC of at least 4
// Notes: bound to every ftcs_setup
`timescale 1ns/1ns
`default_nettype none
module ftcs_setup_sva
  import ftcs_pkg::*;
#(
  parameter int UNIT_CYC = STEP_UNIT_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_sector,
  input wire logic cfg_poll_disable,
  input wire logic cmd_ready_r,
  input wire logic [3:0] drive_busy_r,
  input wire logic step_pulse_r,
  input wire logic xfer_start_r,
  input wire logic [7:0] xfer_first_sector_r,
  input wire logic poll_active_r,
  input wire logic result_valid_r,
  input wire logic [7:0] first_result_status_r,
  input wire logic [7:0] result_cyl_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_busy_step: assert property (
    step_pulse_r |-> drive_busy_r != 4'h0)
    else $error("step without busy drive");
  chk_seek_first: assert property (
    xfer_start_r |-> drive_busy_r == 4'h0)
    else $error("transfer started during seek");
  chk_step_space: assert property (
    step_pulse_r |=> !step_pulse_r [*5])
    else $error("steps too close");
  chk_poll_off: assert property (
    poll_active_r |-> !$past(cfg_poll_disable))
    else $error("polling while disabled");
  chk_take_busy: assert property (
    cmd_valid && cmd_ready_r |=> !cmd_ready_r)
    else $error("command not taken");
  chk_ready_back: assert property (
    result_valid_r |=> cmd_ready_r)
    else $error("not ready after result");
  chk_result_hold: assert property (
    !result_valid_r |-> $stable(result_cyl_r)
      && $stable(first_result_status_r))
    else $error("result changed without pulse");
  chk_sector_pass: assert property (
    xfer_start_r |-> xfer_first_sector_r == cmd_sector)
    else $error("first sector wrong");
endmodule // ftcs_setup_sva
bind ftcs_setup ftcs_setup_sva #(.UNIT_CYC(UNIT_CYC)) u_sva (
  .clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
  .cmd_sector(cmd_sector), .cfg_poll_disable(cfg_poll_disable),
  .cmd_ready_r(cmd_ready_r), .drive_busy_r(drive_busy_r),
  .step_pulse_r(step_pulse_r), .xfer_start_r(xfer_start_r),
  .xfer_first_sector_r(xfer_first_sector_r),
  .poll_active_r(poll_active_r), .result_valid_r(result_valid_r),
  .first_result_status_r(first_result_status_r),
  .result_cyl_r(result_cyl_r));
`default_nettype wire

// file: testbench/ftcs_engine_model.sv
// Purpose: transfer engine stand-in
// Assumes: one transfer per start pulse
// Notes: status lines toggle when not reporting
`timescale 1ns/1ns
`default_nettype none
module ftcs_engine_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic xfer_start,
  output logic xfer_done,
  output logic xfer_fail,
  output logic [7:0] xfer_st1,
  output logic [7:0] xfer_st2
);
  logic [2:0] cnt;
  always @(posedge clk) begin
    xfer_done <= 1'b0;
    xfer_fail <= 1'b0;
    xfer_st1 <= ~xfer_st1;
    xfer_st2 <= ~xfer_st2;
    if (!rst_b) begin
      cnt <= 3'h0;
      xfer_st1 <= 8'h00;
      xfer_st2 <= 8'h00;
    end else if (xfer_start) begin
      cnt <= 3'h3;
    end else if (cnt == 3'h1) begin
      cnt <= 3'h0;
      xfer_done <= 1'b1;
      xfer_st1 <= 8'h21;
      xfer_st2 <= 8'h12;
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
    end
  end
endmodule // ftcs_engine_model
`default_nettype wire

// file: testbench/ftcs_setup_tb.sv
// Purpose: directed bench for ftcs_setup
// Assumes: UNIT_CYC scaled to 4
// Notes: drive 1, head 1 throughout
`timescale 1ns/1ns
`default_nettype none
module ftcs_setup_tb
  import ftcs_pkg::*;
();
  localparam int U = 4;
  logic clk = 1'b0, rst_b = 1'b0, cmd_valid = 1'b0, cmd_head = 1'b1;
  logic enable_count_flag = 1'b0, cfg_implied_seek = 1'b0;
  logic cfg_poll_disable = 1'b0, write_gate_option = 1'b0;
  logic drive_fault = 1'b0, drive_track0 = 1'b0, wr_req = 1'b0;
  logic [1:0] cmd_drive = 2'h1;
  logic [3:0] step_interval = 4'hF;
  logic [7:0] cmd_opcode = 8'h00, cmd_cyl = 8'h00, cmd_sector = 8'h00;
  logic [7:0] sector_count = 8'h00, precomp_track = 8'h00;
  logic xfer_done, xfer_fail, cmd_ready_r, step_pulse_r, step_dir_r;
  logic xfer_start_r, xfer_count_en_r, precomp_en_r, drive_we_r;
  logic poll_active_r, result_valid_r;
  logic [1:0] xfer_kind_r;
  logic [3:0] drive_busy_r;
  logic [7:0] xfer_st1, xfer_st2, xfer_first_sector_r, xfer_count_r;
  logic [7:0] first_result_status_r, result_st1_r, result_st2_r;
  logic [7:0] result_st3_r, result_cyl_r;
  int checks = 0, fail_count = 0, steps = 0, starts = 0, cyc = 0;
  int last = 0, gap = 0;
  always #20 clk = ~clk;
  ftcs_setup #(.UNIT_CYC(U)) u_dut (.clk(clk), .rst_b(rst_b),
    .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
    .cmd_drive(cmd_drive), .cmd_head(cmd_head), .cmd_cyl(cmd_cyl),
    .cmd_sector(cmd_sector), .sector_count(sector_count),
    .enable_count_flag(enable_count_flag),
    .cfg_implied_seek(cfg_implied_seek),
    .cfg_poll_disable(cfg_poll_disable),
    .write_gate_option(write_gate_option),
    .precomp_track(precomp_track), .step_interval(step_interval),
    .drive_fault(drive_fault), .drive_track0(drive_track0),
    .wr_req(wr_req), .xfer_done(xfer_done), .xfer_fail(xfer_fail),
    .xfer_st1(xfer_st1), .xfer_st2(xfer_st2),
    .cmd_ready_r(cmd_ready_r), .drive_busy_r(drive_busy_r),
    .step_pulse_r(step_pulse_r), .step_dir_r(step_dir_r),
    .xfer_start_r(xfer_start_r), .xfer_kind_r(xfer_kind_r),
    .xfer_first_sector_r(xfer_first_sector_r),
    .xfer_count_r(xfer_count_r), .xfer_count_en_r(xfer_count_en_r),
    .precomp_en_r(precomp_en_r), .drive_we_r(drive_we_r),
    .poll_active_r(poll_active_r), .result_valid_r(result_valid_r),
    .first_result_status_r(first_result_status_r),
    .result_st1_r(result_st1_r), .result_st2_r(result_st2_r),
    .result_st3_r(result_st3_r), .result_cyl_r(result_cyl_r));
  ftcs_engine_model u_eng (.clk(clk), .rst_b(rst_b),
    .xfer_start(xfer_start_r), .xfer_done(xfer_done),
    .xfer_fail(xfer_fail), .xfer_st1(xfer_st1), .xfer_st2(xfer_st2));
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (step_pulse_r) begin
      steps <= steps + 1;
      gap <= cyc - last;
      last <= cyc;
    end
    if (xfer_start_r) starts <= starts + 1;
  end
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    checks++;
    if (e !== s) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic go(logic [7:0] op, logic [7:0] cyl);
    int n;
    n = 0;
    @(negedge clk);
    while (cmd_ready_r !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    cmd_opcode <= op;
    cmd_cyl <= cyl;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    do begin
      @(negedge clk);
      n++;
    end while (result_valid_r !== 1'b1 && n < 3000);
    chk("result", 8'h01, {7'h00, result_valid_r});
  endtask
  task automatic t_kinds;
    logic [4:0] op [6] = '{OP_READ, OP_READ_DEL, OP_WRITE,
      OP_WRITE_DEL, OP_VERIFY, OP_FORMAT};
    logic [7:0] kd [6] = '{8'h0, 8'h0, 8'h1, 8'h1, 8'h2, 8'h3};
    int s;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      s = starts;
      cmd_sector <= 8'h20 + 8'(i);
      sector_count <= 8'h10 + 8'(i);
      enable_count_flag <= (i == 4);
      go({3'h0, op[i]}, 8'h00);
      chk("kind", kd[i], {6'h00, xfer_kind_r});
      chk("starts", 8'h01, 8'(starts - s));
      chk("sector", 8'h20 + 8'(i), xfer_first_sector_r);
      chk("st0", 8'h05, first_result_status_r);
      chk("st1", 8'h21, result_st1_r);
      chk("st2", 8'h12, result_st2_r);
      chk("st3", 8'h05, result_st3_r);
      if (i > 3) chk("count", 8'h10 + 8'(i), xfer_count_r);
      if (i == 4) chk("count_en", 8'h01, {7'h00, xfer_count_en_r});
    end
    go(8'h1F, 8'h00);
    chk("st0 bad", 8'h85, first_result_status_r);
  endtask
  task automatic t_seek;
    logic [7:0] tr [4] = '{8'h00, 8'h03, 8'h04, 8'hFF};
    int s;
    @(posedge clk);
    s = steps;
    cfg_implied_seek <= 1'b1;
    go({3'h0, OP_READ}, 8'h03);
    chk("steps", 8'h03, 8'(steps - s));
    chk("gap", 8'h01, {7'h00, gap >= 6 && gap <= 9});
    chk("cyl", 8'h03, result_cyl_r);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      precomp_track <= tr[i];
      repeat (3) @(negedge clk);
      chk("precomp", {7'h00, i < 2}, {7'h00, precomp_en_r});
    end
  endtask
  task automatic t_fail;
    int s, t;
    @(posedge clk);
    drive_fault <= 1'b1;
    s = steps;
    t = starts;
    go({3'h0, OP_WRITE}, 8'h09);
    chk("st0 fail", 8'h55, first_result_status_r);
    chk("cyl fail", 8'h03, result_cyl_r);
    chk("steps fail", 8'h00, 8'(steps - s));
    chk("st1 fail", 8'h00, result_st1_r);
    chk("starts", 8'h00, 8'(starts - t));
    @(posedge clk);
    drive_fault <= 1'b0;
  endtask
  task automatic t_offs;
    logic [7:0] p;
    @(posedge clk);
    step_interval <= 4'hE;
    p = result_cyl_r;
    go({3'h0, OP_OFFSET_SEEK}, 8'h02);
    chk("cyl up", p + 8'h02, result_cyl_r);
    chk("dir up", 8'h01, {7'h00, step_dir_r});
    chk("st0 offs", 8'h25, first_result_status_r);
    chk("gap", 8'h01, {7'h00, gap >= 10 && gap <= 13});
    go({3'h2, OP_OFFSET_SEEK}, 8'h01);
    chk("cyl down", p + 8'h01, result_cyl_r);
    chk("dir down", 8'h00, {7'h00, step_dir_r});
  endtask
  task automatic t_misc;
    int d [2];
    for (int g = 0; g < 2; g++) begin
      @(posedge clk);
      cfg_poll_disable <= g[0];
      write_gate_option <= g[0];
      repeat (2) @(negedge clk);
      chk("poll", {7'h00, ~g[0]}, {7'h00, poll_active_r});
      @(posedge clk);
      wr_req <= 1'b1;
      d[g] = 0;
      do begin
        @(negedge clk);
        d[g]++;
      end while (drive_we_r !== 1'b1 && d[g] < 9);
      @(posedge clk);
      wr_req <= 1'b0;
      repeat (3) @(posedge clk);
    end
    chk("we lead", 8'h01, 8'(d[0] - d[1]));
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #(20000 * 40);
    fail_count++;
    results();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_kinds();
    t_seek();
    t_fail();
    t_offs();
    t_misc();
    results();
  end
endmodule // ftcs_setup_tb
`default_nettype wire
